// ==== shared/ntsp_consts.vh ====
// Constants for the timekeeping SRAM port: map, fields, timing.
// Assumes a single 50 MHz clock and pins sampled synchronously.
`ifndef NTSP_CONSTS_VH
`define NTSP_CONSTS_VH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define NTSP_AW 19
`define NTSP_MEM_WORDS 524288

// ----------------------------------------
// Timekeeping register addresses
// ----------------------------------------
`define NTSP_ADR_CEN 19'h7FFF8
`define NTSP_ADR_SEC 19'h7EFF9
`define NTSP_ADR_MIN 19'h7FFFA
`define NTSP_ADR_HR 19'h7FFFB
`define NTSP_ADR_DAY 19'h7FFFC
`define NTSP_ADR_DATE 19'h7FFFD
`define NTSP_ADR_MON 19'h7FFFE
`define NTSP_ADR_YR 19'h7FFFF

// Register slot index (low address bits)
`define NTSP_IX_CEN 3'h0
`define NTSP_IX_SEC 3'h1
`define NTSP_IX_MIN 3'h2
`define NTSP_IX_HR 3'h3
`define NTSP_IX_DAY 3'h4
`define NTSP_IX_DATE 3'h5
`define NTSP_IX_MON 3'h6
`define NTSP_IX_YR 3'h7

// ----------------------------------------
// Field bits and masks
// ----------------------------------------
`define NTSP_BIT_WRHOLD 7
`define NTSP_BIT_RDHOLD 6
`define NTSP_BIT_OSCSTOP 7
`define NTSP_BIT_BATGOOD 7
`define NTSP_BIT_RATETEST 6
`define NTSP_BIT_SECLSB 0
`define NTSP_MSK_CEN 8'h3F
`define NTSP_MSK_SEC 8'h7F
`define NTSP_MSK_MIN 8'h7F
`define NTSP_MSK_HR 8'h3F
`define NTSP_MSK_DAY 8'h07
`define NTSP_MSK_DATE 8'h3F
`define NTSP_MSK_MON 8'h1F
`define NTSP_MSK_YR 8'hFF

// ----------------------------------------
// BCD ranges and reset values
// ----------------------------------------
`define NTSP_MAX_SEC 8'h59
`define NTSP_MAX_MIN 8'h59
`define NTSP_MAX_HR 8'h23
`define NTSP_MAX_DAY 8'h07
`define NTSP_MAX_MON 8'h12
`define NTSP_MAX_YR 8'h99
`define NTSP_MAX_CEN 8'h39
`define NTSP_MIN_ZERO 8'h00
`define NTSP_MIN_ONE 8'h01
`define NTSP_DIM_31 8'h31
`define NTSP_DIM_30 8'h30
`define NTSP_DIM_29 8'h29
`define NTSP_DIM_28 8'h28
`define NTSP_MON_FEB 8'h02
`define NTSP_MON_APR 8'h04
`define NTSP_MON_JUN 8'h06
`define NTSP_MON_SEP 8'h09
`define NTSP_MON_NOV 8'h11
`define NTSP_BCD_NINE 4'h9
`define NTSP_RST_BYTE 8'h00
`define NTSP_FILL_BYTE 8'hFF

// ----------------------------------------
// Timing in ns and derived cycle counts
// ----------------------------------------
`define NTSP_CLK_NS 20
`define NTSP_AA_NS 70
`define NTSP_CEA_NS 70
`define NTSP_OEA_NS 35
`define NTSP_OH_NS 5
`define NTSP_AA_CYC ((`NTSP_AA_NS + `NTSP_CLK_NS - 1) / `NTSP_CLK_NS)
`define NTSP_CEA_CYC ((`NTSP_CEA_NS + `NTSP_CLK_NS - 1) / `NTSP_CLK_NS)
`define NTSP_OEA_CYC ((`NTSP_OEA_NS + `NTSP_CLK_NS - 1) / `NTSP_CLK_NS)
`define NTSP_OH_CYC ((`NTSP_OH_NS + `NTSP_CLK_NS - 1) / `NTSP_CLK_NS)
`define NTSP_CNT_W 3
`define NTSP_CNT_SAT 3'h7

// Clock divider: 1024 Hz strobe, 1 Hz after 1024 strobes
`define NTSP_DIV_1K 48828
`define NTSP_DIV_W 16
`define NTSP_SUB_W 10
`define NTSP_SUB_LAST 10'h3FF

`endif

// ==== rtl/ntsp_rtc_count.v ====
// BCD calendar counters that run behind the user-visible registers.
// Assumes a one-cycle tick per second and a load strobe from the port logic.
`timescale 1ns/100ps

module ntsp_rtc_count (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Control
    input wire tick_i,
    input wire load_i,
    // Load values
    input wire [7:0] ld_sec_i,
    input wire [7:0] ld_min_i,
    input wire [7:0] ld_hr_i,
    input wire [7:0] ld_day_i,
    input wire [7:0] ld_date_i,
    input wire [7:0] ld_mon_i,
    input wire [7:0] ld_yr_i,
    input wire [7:0] ld_cen_i,
    // Running counts
    output reg [7:0] sec_o,
    output reg [7:0] min_o,
    output reg [7:0] hr_o,
    output reg [7:0] day_o,
    output reg [7:0] date_o,
    output reg [7:0] mon_o,
    output reg [7:0] yr_o,
    output reg [7:0] cen_o
);
`include "ntsp_consts.vh"

// ----------------------------------------
// Helpers
// ----------------------------------------
// Next BCD value, wrapping from top back to floor
function [7:0] ntsp_bcd_inc;
    input [7:0] v;
    input [7:0] top;
    input [7:0] floor;
    begin
        if (v >= top) begin
            ntsp_bcd_inc = floor;
        end else if (v[3:0] >= `NTSP_BCD_NINE) begin
            ntsp_bcd_inc = {v[7:4] + 4'h1, 4'h0};
        end else begin
            ntsp_bcd_inc = v + 8'h01;
        end
    end
endfunction

// Last date of the month; leap years are those divisible by four
function [7:0] ntsp_last_date;
    input [7:0] mon;
    input [7:0] yr;
    reg leap;
    begin
        leap = yr[4] ? (yr[3:0] == 4'h2 || yr[3:0] == 4'h6)
                     : (yr[3:0] == 4'h0 || yr[3:0] == 4'h4 || yr[3:0] == 4'h8);
        if (mon == `NTSP_MON_FEB) begin
            ntsp_last_date = leap ? `NTSP_DIM_29 : `NTSP_DIM_28;
        end else if (mon == `NTSP_MON_APR || mon == `NTSP_MON_JUN ||
                     mon == `NTSP_MON_SEP || mon == `NTSP_MON_NOV) begin
            ntsp_last_date = `NTSP_DIM_30;
        end else begin
            ntsp_last_date = `NTSP_DIM_31;
        end
    end
endfunction

// ----------------------------------------
// Counter chain
// ----------------------------------------
// Load wins over a tick; each field except day carries into the next at its top
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        sec_o <= `NTSP_MIN_ZERO;
        min_o <= `NTSP_MIN_ZERO;
        hr_o <= `NTSP_MIN_ZERO;
        day_o <= `NTSP_MIN_ONE;
        date_o <= `NTSP_MIN_ONE;
        mon_o <= `NTSP_MIN_ONE;
        yr_o <= `NTSP_MIN_ZERO;
        cen_o <= `NTSP_MIN_ZERO;
    end else if (load_i) begin
        sec_o <= ld_sec_i;
        min_o <= ld_min_i;
        hr_o <= ld_hr_i;
        day_o <= ld_day_i;
        date_o <= ld_date_i;
        mon_o <= ld_mon_i;
        yr_o <= ld_yr_i;
        cen_o <= ld_cen_i;
    end else if (tick_i) begin
        sec_o <= ntsp_bcd_inc(sec_o, `NTSP_MAX_SEC, `NTSP_MIN_ZERO);
        if (sec_o >= `NTSP_MAX_SEC) begin
            min_o <= ntsp_bcd_inc(min_o, `NTSP_MAX_MIN, `NTSP_MIN_ZERO);
            if (min_o >= `NTSP_MAX_MIN) begin
                hr_o <= ntsp_bcd_inc(hr_o, `NTSP_MAX_HR, `NTSP_MIN_ZERO);
                if (hr_o >= `NTSP_MAX_HR) begin
                    day_o <= ntsp_bcd_inc(day_o, `NTSP_MAX_DAY, `NTSP_MIN_ONE);
                    date_o <= ntsp_bcd_inc(date_o, ntsp_last_date(mon_o, yr_o), `NTSP_MIN_ONE);
                    if (date_o >= ntsp_last_date(mon_o, yr_o)) begin
                        mon_o <= ntsp_bcd_inc(mon_o, `NTSP_MAX_MON, `NTSP_MIN_ONE);
                        if (mon_o >= `NTSP_MAX_MON) begin
                            yr_o <= ntsp_bcd_inc(yr_o, `NTSP_MAX_YR, `NTSP_MIN_ZERO);
                            if (yr_o >= `NTSP_MAX_YR) begin
                                cen_o <= ntsp_bcd_inc(cen_o, `NTSP_MAX_CEN, `NTSP_MIN_ZERO);
                            end
                        end
                    end
                end
            end
        end
    end
end

endmodule

// ==== rtl/ntsp_top.v ====
// Bytewide SRAM port with eight BCD timekeeping registers, seven at the top and seconds at 7EFF9.
// Assumes host pins are synchronous to ref_clk_i; power_fail_i comes from a supply monitor.
`timescale 1ns/100ps

module ntsp_top #(
    parameter DIV_1K = `NTSP_DIV_1K
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Host bus
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [18:0] addr_i,
    input wire [7:0] dq_i,
    output reg [7:0] dq_o,
    output reg dq_oe_n_o,
    // Supply and battery
    input wire power_fail_i,
    input wire battery_good_i,
    output reg pf_rst_n_o,
    output reg pf_rst_oe_n_o
);
`include "ntsp_consts.vh"

// ----------------------------------------
// Helpers
// ----------------------------------------
// Timekeeping register hit
function ntsp_is_tk;
    input [18:0] a;
    begin
        ntsp_is_tk = (a == `NTSP_ADR_CEN) || (a == `NTSP_ADR_SEC) || (a == `NTSP_ADR_MIN) ||
                     (a == `NTSP_ADR_HR) || (a == `NTSP_ADR_DAY) || (a == `NTSP_ADR_DATE) ||
                     (a == `NTSP_ADR_MON) || (a == `NTSP_ADR_YR);
    end
endfunction

// Saturating access counter step
function [2:0] ntsp_sat;
    input [2:0] c;
    begin
        ntsp_sat = (c == `NTSP_CNT_SAT) ? c : c + 3'h1;
    end
endfunction

// ----------------------------------------
// Storage
// ----------------------------------------
reg [7:0] mem_r [0:`NTSP_MEM_WORDS-1];
reg [7:0] vis_r [0:7];
wire [7:0] cnt_w [0:7];

// Counted bit mask per slot; other bits are control flags or free RAM bits
// A function, since a constant-only combinational process would never run
function [7:0] ntsp_fmask;
    input [2:0] s;
    begin
        case (s)
            `NTSP_IX_CEN: ntsp_fmask = `NTSP_MSK_CEN;
            `NTSP_IX_SEC: ntsp_fmask = `NTSP_MSK_SEC;
            `NTSP_IX_MIN: ntsp_fmask = `NTSP_MSK_MIN;
            `NTSP_IX_HR: ntsp_fmask = `NTSP_MSK_HR;
            `NTSP_IX_DAY: ntsp_fmask = `NTSP_MSK_DAY;
            `NTSP_IX_DATE: ntsp_fmask = `NTSP_MSK_DATE;
            `NTSP_IX_MON: ntsp_fmask = `NTSP_MSK_MON;
            default: ntsp_fmask = `NTSP_MSK_YR;
        endcase
    end
endfunction

// ----------------------------------------
// Control bits and bus qualifiers
// ----------------------------------------
wire wr_hold = vis_r[`NTSP_IX_CEN][`NTSP_BIT_WRHOLD];
wire rd_hold = vis_r[`NTSP_IX_CEN][`NTSP_BIT_RDHOLD];
wire oscillator_stop_bit = vis_r[`NTSP_IX_SEC][`NTSP_BIT_OSCSTOP];
wire rate_test_bit = vis_r[`NTSP_IX_DAY][`NTSP_BIT_RATETEST];
wire rd_act = !ce_n_i && !oe_n_i && we_n_i && !power_fail_i;
wire wr_act = !ce_n_i && !we_n_i && !power_fail_i;
wire [2:0] ix = addr_i[2:0];
wire [31:0] oh_cyc_w = `NTSP_OH_CYC; // Hold count, cut to counter width where loaded

reg [18:0] addr_q_r;
reg ce_q_r;
reg oe_q_r;
reg [2:0] aa_cnt_r;
reg [2:0] ce_cnt_r;
reg [2:0] oe_cnt_r;
reg [2:0] oh_cnt_r;
reg wr_q_r;
reg [18:0] waddr_r;
reg [7:0] wdata_r;
reg bat_en_r;
reg [`NTSP_DIV_W-1:0] div_r;
reg [`NTSP_SUB_W-1:0] sub_r;
reg t512_r;
reg tick_r;
reg [7:0] rd_byte;
reg [7:0] tk_byte;

// ----------------------------------------
// Read data selection
// ----------------------------------------
// Battery flag and rate test bit override stored bits on the way out
always @* begin
    tk_byte = vis_r[ix];
    if (ix == `NTSP_IX_DAY) begin
        tk_byte[`NTSP_BIT_BATGOOD] = battery_good_i;
    end
    if (ix == `NTSP_IX_SEC && rate_test_bit && !oscillator_stop_bit) begin
        tk_byte[`NTSP_BIT_SECLSB] = t512_r;
    end
    rd_byte = ntsp_is_tk(addr_i) ? tk_byte : mem_r[addr_i];
end

// ----------------------------------------
// Read timing
// ----------------------------------------
// Access counters restart on address change or on select/drive activation
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        addr_q_r <= {`NTSP_AW{1'b0}};
        ce_q_r <= 1'b0;
        oe_q_r <= 1'b0;
        aa_cnt_r <= {`NTSP_CNT_W{1'b0}};
        ce_cnt_r <= {`NTSP_CNT_W{1'b0}};
        oe_cnt_r <= {`NTSP_CNT_W{1'b0}};
        oh_cnt_r <= {`NTSP_CNT_W{1'b0}};
    end else begin
        addr_q_r <= addr_i;
        ce_q_r <= !ce_n_i;
        oe_q_r <= !oe_n_i;
        aa_cnt_r <= (addr_i != addr_q_r) ? {`NTSP_CNT_W{1'b0}} : ntsp_sat(aa_cnt_r);
        ce_cnt_r <= (!ce_n_i && !ce_q_r) ? {`NTSP_CNT_W{1'b0}} : ntsp_sat(ce_cnt_r);
        oe_cnt_r <= (!oe_n_i && !oe_q_r) ? {`NTSP_CNT_W{1'b0}} : ntsp_sat(oe_cnt_r);
        if (addr_i != addr_q_r) begin
            oh_cnt_r <= oh_cyc_w[`NTSP_CNT_W-1:0];
        end else if (oh_cnt_r != {`NTSP_CNT_W{1'b0}}) begin
            oh_cnt_r <= oh_cnt_r - 3'h1;
        end
    end
end

// Select and drive must already have been seen, so their counters have restarted
wire acc_done = (aa_cnt_r >= `NTSP_AA_CYC - 1) && (ce_cnt_r >= `NTSP_CEA_CYC - 1) &&
                (oe_cnt_r >= `NTSP_OEA_CYC - 1) && (addr_i == addr_q_r) && ce_q_r && oe_q_r;

// Data pins: driven only in read mode, filler until the access completes
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        dq_o <= `NTSP_FILL_BYTE;
        dq_oe_n_o <= 1'b1;
    end else begin
        dq_oe_n_o <= !rd_act;
        if (!rd_act) begin
            dq_o <= `NTSP_FILL_BYTE;
        end else if (acc_done) begin
            dq_o <= rd_byte;
        end else if (oh_cnt_r == {`NTSP_CNT_W{1'b0}} || addr_i == addr_q_r) begin
            dq_o <= `NTSP_FILL_BYTE;
        end
    end
end

// ----------------------------------------
// Write capture and commit
// ----------------------------------------
// Address and data are sampled through the write; the end of write commits
wire wr_commit = wr_q_r && !wr_act && !power_fail_i;
wire wr_tk = ntsp_is_tk(waddr_r);
wire [2:0] wix = waddr_r[2:0];
wire load_cnt = wr_commit && wr_tk && (wix == `NTSP_IX_CEN) && wr_hold &&
                !wdata_r[`NTSP_BIT_WRHOLD];

always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        wr_q_r <= 1'b0;
        waddr_r <= {`NTSP_AW{1'b0}};
        wdata_r <= `NTSP_RST_BYTE;
    end else begin
        wr_q_r <= wr_act;
        if (wr_act) begin
            waddr_r <= addr_i;
            wdata_r <= dq_i;
        end
    end
end

// Plain array write; contents kept through power fail and backup
always @(posedge ref_clk_i) begin
    if (wr_commit && !wr_tk) begin
        mem_r[waddr_r] <= wdata_r;
    end
end

// ----------------------------------------
// Visible timekeeping registers
// ----------------------------------------
// Host write wins; otherwise counted fields follow the counters unless held
integer i;
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        for (i = 0; i < 8; i = i + 1) begin
            vis_r[i] <= `NTSP_RST_BYTE;
        end
    end else begin
        for (i = 0; i < 8; i = i + 1) begin
            if (wr_commit && wr_tk && wix == i) begin
                vis_r[i] <= wdata_r;
            end else if (!rd_hold && !wr_hold) begin
                vis_r[i] <= (vis_r[i] & ~ntsp_fmask(i[2:0])) | (cnt_w[i] & ntsp_fmask(i[2:0]));
            end
        end
    end
end

// ----------------------------------------
// Oscillator, divider and backup
// ----------------------------------------
// Rate is fixed by DIV_1K; software has no trim control
wire oscillator_run = !oscillator_stop_bit && (!power_fail_i || bat_en_r);
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        div_r <= {`NTSP_DIV_W{1'b0}};
        sub_r <= {`NTSP_SUB_W{1'b0}};
        t512_r <= 1'b0;
        tick_r <= 1'b0;
        bat_en_r <= 1'b0;
    end else begin
        tick_r <= 1'b0;
        if (!power_fail_i) begin
            bat_en_r <= 1'b1;
        end
        if (oscillator_run) begin
            if (div_r >= DIV_1K[`NTSP_DIV_W-1:0] - 16'h0001) begin
                div_r <= {`NTSP_DIV_W{1'b0}};
                t512_r <= !t512_r;
                sub_r <= sub_r + 10'h001;
                tick_r <= (sub_r == `NTSP_SUB_LAST);
            end else begin
                div_r <= div_r + 16'h0001;
            end
        end
    end
end

// ----------------------------------------
// Power-fail reset pin
// ----------------------------------------
// Open drain: pulls low while supply is below threshold
always @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
        pf_rst_n_o <= 1'b0;
        pf_rst_oe_n_o <= 1'b1;
    end else begin
        pf_rst_n_o <= 1'b0;
        pf_rst_oe_n_o <= !power_fail_i;
    end
end

// ----------------------------------------
// Counters
// ----------------------------------------
// Century value comes from the write being committed; others from visible copies
ntsp_rtc_count u_count (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .tick_i(tick_r),
    .load_i(load_cnt),
    .ld_sec_i(vis_r[`NTSP_IX_SEC] & `NTSP_MSK_SEC),
    .ld_min_i(vis_r[`NTSP_IX_MIN] & `NTSP_MSK_MIN),
    .ld_hr_i(vis_r[`NTSP_IX_HR] & `NTSP_MSK_HR),
    .ld_day_i(vis_r[`NTSP_IX_DAY] & `NTSP_MSK_DAY),
    .ld_date_i(vis_r[`NTSP_IX_DATE] & `NTSP_MSK_DATE),
    .ld_mon_i(vis_r[`NTSP_IX_MON] & `NTSP_MSK_MON),
    .ld_yr_i(vis_r[`NTSP_IX_YR] & `NTSP_MSK_YR),
    .ld_cen_i(wdata_r & `NTSP_MSK_CEN),
    .sec_o(cnt_w[`NTSP_IX_SEC]),
    .min_o(cnt_w[`NTSP_IX_MIN]),
    .hr_o(cnt_w[`NTSP_IX_HR]),
    .day_o(cnt_w[`NTSP_IX_DAY]),
    .date_o(cnt_w[`NTSP_IX_DATE]),
    .mon_o(cnt_w[`NTSP_IX_MON]),
    .yr_o(cnt_w[`NTSP_IX_YR]),
    .cen_o(cnt_w[`NTSP_IX_CEN])
);

endmodule

// ==== tb/ntsp_top_sva.sv ====
// Checker for the timekeeping SRAM port: read enable, release and power-fail pin.
// Assumes it is bound to ntsp_top and sees only that module's ports.
`timescale 1ns/100ps

module ntsp_top_sva #(
    parameter DIV_1K = 4
) (
    // Clock and reset
    input wire ref_clk_i,
    input wire reset_n_i,
    // Host bus
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [18:0] addr_i,
    input wire [7:0] dq_i,
    input wire [7:0] dq_o,
    input wire dq_oe_n_o,
    // Supply and battery
    input wire power_fail_i,
    input wire battery_good_i,
    input wire pf_rst_n_o,
    input wire pf_rst_oe_n_o
);
    // ----------------------------------------
    // Common clocking
    // ----------------------------------------
    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    // Select falls with output drive already low: a fresh access starts
    sequence s_sel_fall;
        $fell(ce_n_i) && !oe_n_i && we_n_i && !power_fail_i;
    endsequence
    // Filler stays on the lines while the access delay runs
    sequence s_filler_run;
        (dq_o == 8'hFF) [*3];
    endsequence

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    property p_rd_drive;
        !ce_n_i && !oe_n_i && we_n_i && !power_fail_i |=> !dq_oe_n_o;
    endproperty
    property p_no_sel;
        ce_n_i || oe_n_i |=> dq_oe_n_o;
    endproperty
    property p_wr_release;
        !ce_n_i && !we_n_i |=> dq_oe_n_o;
    endproperty
    property p_pf_block;
        power_fail_i |=> dq_oe_n_o;
    endproperty
    property p_filler;
        dq_oe_n_o |-> dq_o == 8'hFF;
    endproperty
    property p_access_wait;
        s_sel_fall |=> s_filler_run;
    endproperty
    property p_pf_assert;
        power_fail_i |=> !pf_rst_oe_n_o && !pf_rst_n_o;
    endproperty
    property p_pf_clear;
        !power_fail_i ##1 !power_fail_i |=> pf_rst_oe_n_o;
    endproperty

    a_rd_drive: assert property (p_rd_drive) else $error("outputs not driven on read");
    a_no_sel: assert property (p_no_sel) else $error("outputs driven while unselected");
    a_wr_release: assert property (p_wr_release) else $error("outputs driven in write");
    a_pf_block: assert property (p_pf_block) else $error("read allowed in power fail");
    a_filler: assert property (p_filler) else $error("released lines not filler");
    a_access_wait: assert property (p_access_wait) else $error("data before access delay");
    a_pf_assert: assert property (p_pf_assert) else $error("power-fail reset not asserted");
    a_pf_clear: assert property (p_pf_clear) else $error("power-fail reset held too long");
endmodule

bind ntsp_top ntsp_top_sva #(.DIV_1K(DIV_1K)) u_sva (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
    .ce_n_i(ce_n_i), .oe_n_i(oe_n_i), .we_n_i(we_n_i), .addr_i(addr_i), .dq_i(dq_i), .dq_o(dq_o),
    .dq_oe_n_o(dq_oe_n_o), .power_fail_i(power_fail_i), .battery_good_i(battery_good_i),
    .pf_rst_n_o(pf_rst_n_o), .pf_rst_oe_n_o(pf_rst_oe_n_o));

// ==== tb/ntsp_host_model.sv ====
// Host model driving the bytewide bus: single-byte reads and writes.
// Assumes the device answers reads four edges after the request is seen.
`timescale 1ns/100ps

module ntsp_host_model (
    // Clock
    input wire clk_i,
    // Read data from the device
    input wire [7:0] dq_i,
    // Bus drive
    output reg ce_n_o,
    output reg oe_n_o,
    output reg we_n_o,
    output reg [18:0] addr_o,
    output reg [7:0] dq_o
);
    // Idle bus at time zero
    initial begin
        ce_n_o = 1'b1;
        oe_n_o = 1'b1;
        we_n_o = 1'b1;
        addr_o = 19'h00000;
        dq_o = 8'h00;
    end

    // Write one byte; output drive stays high, address held to the end
    task wr(input [18:0] a, input [7:0] d);
        begin
            @(negedge clk_i);
            ce_n_o = 1'b0;
            we_n_o = 1'b0;
            addr_o = a;
            dq_o = d;
            @(negedge clk_i);
            ce_n_o = 1'b1;
            we_n_o = 1'b1;
            @(negedge clk_i);
            addr_o = ~a;
            dq_o = ~d;
        end
    endtask

    // Read one byte after the full access delay, then release
    task rd(input [18:0] a, output [7:0] d);
        begin
            @(negedge clk_i);
            ce_n_o = 1'b0;
            oe_n_o = 1'b0;
            addr_o = a;
            repeat (5) @(negedge clk_i);
            d = dq_i;
            ce_n_o = 1'b1;
            oe_n_o = 1'b1;
            addr_o = ~a;
        end
    endtask

    // Read with select arriving last: address and output drive settle first
    task rd_late(input [18:0] a, output [7:0] early, output [7:0] d);
        begin
            @(negedge clk_i);
            oe_n_o = 1'b0;
            addr_o = a;
            repeat (5) @(negedge clk_i);
            ce_n_o = 1'b0;
            @(negedge clk_i);
            early = dq_i;
            repeat (4) @(negedge clk_i);
            d = dq_i;
            ce_n_o = 1'b1;
            oe_n_o = 1'b1;
            addr_o = ~a;
        end
    endtask
endmodule

// ==== tb/ntsp_top_tb.sv ====
// Testbench for the timekeeping SRAM port: memory, clock registers, power fail.
// Assumes a 50 MHz clock and the 1024 Hz divider DIV_1K shortened to 4 for speed.
`timescale 1ns/100ps
`include "ntsp_consts.vh"

module ntsp_top_tb;
    reg ref_clk_i;
    reg reset_n_i;
    reg power_fail_i;
    reg battery_good_i;
    wire ce_n;
    wire oe_n;
    wire we_n;
    wire [18:0] addr;
    wire [7:0] dq_w;
    wire [7:0] dq_r;
    wire dq_oe_n;
    wire pf_n;
    wire pf_oe_n;
    integer fails;
    integer n_compared;
    reg [7:0] d;
    reg [7:0] d_early;

    ntsp_top #(.DIV_1K(4)) DUT (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .ce_n_i(ce_n), .oe_n_i(oe_n),
        .we_n_i(we_n), .addr_i(addr), .dq_i(dq_w), .dq_o(dq_r), .dq_oe_n_o(dq_oe_n),
        .power_fail_i(power_fail_i), .battery_good_i(battery_good_i), .pf_rst_n_o(pf_n),
        .pf_rst_oe_n_o(pf_oe_n));
    ntsp_host_model HOST (.clk_i(ref_clk_i), .dq_i(dq_r), .ce_n_o(ce_n), .oe_n_o(oe_n), .we_n_o(we_n),
        .addr_o(addr), .dq_o(dq_w));

    // ----------------------------------------
    // Checking helpers
    // ----------------------------------------
    task chk(input [7:0] got, input [7:0] exp);
        begin
            n_compared = n_compared + 1;
            if (got !== exp) begin
                fails = fails + 1;
                $display("mismatch at %0t got %h exp %h", $time, got, exp);
            end
        end
    endtask

    // Read a location and compare with the expected byte
    task rchk(input [18:0] a, input [7:0] e);
        begin
            HOST.rd(a, d);
            chk(d, e);
        end
    endtask

    task report_and_stop;
        begin
            if (fails == 0 && n_compared > 0)
                $display("All checks passed");
            else
                $display("Checks failed");
            $finish;
        end
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    // Back-to-back writes, plain RAM at 7FFF9 between the century and minutes registers
    task t_ram;
        begin
            HOST.wr(19'h00000, 8'hA5);
            HOST.wr(19'h7FFF9, 8'h3C);
            rchk(19'h00000, 8'hA5);
            rchk(19'h7FFF9, 8'h3C);
            HOST.wr(19'h00000, 8'h5A);
            rchk(19'h00000, 8'h5A);
            HOST.rd_late(19'h00000, d_early, d);
            chk(d_early, 8'hFF);
            chk(d, 8'h5A);
        end
    endtask

    // Load 23:59:59 Feb 28 with the oscillator stopped
    task t_stop;
        begin
            HOST.wr(`NTSP_ADR_CEN, 8'h80);
            HOST.wr(`NTSP_ADR_YR, 8'h01);
            HOST.wr(`NTSP_ADR_MON, 8'h02);
            HOST.wr(`NTSP_ADR_DATE, 8'h28);
            HOST.wr(`NTSP_ADR_DAY, 8'h83);
            HOST.wr(`NTSP_ADR_HR, 8'hE3);
            HOST.wr(`NTSP_ADR_MIN, 8'h59);
            HOST.wr(`NTSP_ADR_SEC, 8'hD9);
            battery_good_i = 1'b0;
            rchk(`NTSP_ADR_DAY, 8'h03);
            battery_good_i = 1'b1;
            rchk(`NTSP_ADR_DAY, 8'h83);
            rchk(`NTSP_ADR_HR, 8'hE3);
            HOST.wr(`NTSP_ADR_CEN, 8'h20);
            repeat (4200) @(negedge ref_clk_i);
            rchk(`NTSP_ADR_MIN, 8'h59);
            rchk(`NTSP_ADR_SEC, 8'hD9);
            rchk(`NTSP_ADR_CEN, 8'h20);
        end
    endtask

    // Restart the oscillator and cross into March of a common year
    task t_roll;
        begin
            HOST.wr(`NTSP_ADR_CEN, 8'h80);
            HOST.wr(`NTSP_ADR_SEC, 8'h59);
            HOST.wr(`NTSP_ADR_CEN, 8'h20);
            repeat (4200) @(negedge ref_clk_i);
            rchk(`NTSP_ADR_MIN, 8'h00);
            rchk(`NTSP_ADR_HR, 8'hC0);
            rchk(`NTSP_ADR_DAY, 8'h84);
            rchk(`NTSP_ADR_DATE, 8'h01);
            rchk(`NTSP_ADR_MON, 8'h03);
            rchk(`NTSP_ADR_YR, 8'h01);
        end
    endtask

    // Supply failure blocks a write and a read, pulls the reset pin low
    task t_pf;
        begin
            power_fail_i = 1'b1;
            HOST.wr(19'h00000, 8'h11);
            HOST.rd(19'h00000, d);
            chk(d, 8'hFF);
            chk({7'h00, pf_oe_n}, 8'h00);
            power_fail_i = 1'b0;
            repeat (2) @(negedge ref_clk_i);
            chk({7'h00, pf_oe_n}, 8'h01);
            rchk(19'h00000, 8'h5A);
            rchk(`NTSP_ADR_DATE, 8'h01);
        end
    endtask

    // ----------------------------------------
    // Clock, main sequence and watchdog
    // ----------------------------------------
    initial begin
        ref_clk_i = 1'b0;
        forever #10 ref_clk_i = ~ref_clk_i;
    end

    initial begin
        fails = 0;
        n_compared = 0;
        reset_n_i = 1'b0;
        power_fail_i = 1'b0;
        battery_good_i = 1'b1;
        repeat (16) @(negedge ref_clk_i);
        reset_n_i = 1'b1;
        t_ram;
        t_stop;
        t_roll;
        t_pf;
        report_and_stop;
    end

    // Run needs about 9000 cycles
    initial begin
        repeat (30000) @(posedge ref_clk_i);
        fails = fails + 1;
        report_and_stop;
    end
endmodule
